/* File: sim/deec_tc_model.sv */
// partner model: transfer controller and early-completion code source
`timescale 1ns/100ps
module deec_tc_model (
  input  wire logic             clk,
  input  wire logic             send,
  input  wire logic             via_early,
  input  wire logic [5:0]       code,
  output deec_pkg::deec_chain_t tc_chain,
  output deec_pkg::deec_chain_t early_chain
);
  // ==========================================
  // one-cycle completion code pulse per send
  always_ff @(posedge clk) begin
    tc_chain <= '0;
    early_chain <= '0;
    if (send && via_early) early_chain <= '{1'b1, 1'b1, 1'b0, code};
    else if (send) tc_chain <= '{1'b1, 1'b0, 1'b1, code};
  end
endmodule

/* File: sim/deec_top_checker.sv */
// checker: port-level assertions for the event block
`timescale 1ns/100ps
module deec_top_checker (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic [7:0]            avs_address,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic                  avs_waitrequest,
  input wire deec_pkg::deec_chain_t tc_chain,
  input wire deec_pkg::deec_chain_t early_chain,
  input wire deec_pkg::deec_vec_t   serviced,
  input wire deec_pkg::deec_vec_t   pending,
  input wire logic                  request_any
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] ch_keep, man_keep;
  assign ch_keep  = pending.chained & ~serviced.chained;
  assign man_keep = pending.manual & ~serviced.manual;
  sequence s_tc_set;
    tc_chain.valid && tc_chain.final_chain_en && !tc_chain.completion_code[5];
  endsequence
  sequence s_man_wr;
    avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable == 4'hf;
  endsequence
  AST_CHAIN_SET: assert property (s_tc_set |=> pending.chained[$past(tc_chain.completion_code[4:0])])
    else $error("chained bit not set by completion code");
  AST_EARLY_SET: assert property (early_chain.valid && early_chain.inter_chain_en && !early_chain.completion_code[5]
    |=> pending.chained[$past(early_chain.completion_code[4:0])])
    else $error("chained bit not set by early completion");
  AST_CHAIN_HOLD: assert property (1'b1 |=> ($past(ch_keep) & ~pending.chained) == 32'h0)
    else $error("chained bit dropped without service");
  AST_CHAIN_CLEAR: assert property (serviced.chained[3] && !tc_chain.valid && !early_chain.valid
    |=> !pending.chained[3])
    else $error("chained bit not cleared after service");
  AST_SET_WINS: assert property (s_tc_set ##0 serviced.chained[tc_chain.completion_code[4:0]]
    |=> pending.chained[$past(tc_chain.completion_code[4:0])])
    else $error("service beat a concurrent chain set");
  AST_NO_SPONT: assert property ($rose(pending.chained[3]) |-> $past(tc_chain.valid) || $past(early_chain.valid))
    else $error("chained bit rose without a completion code");
  AST_MAN_SET: assert property (s_man_wr |=> (pending.manual & $past(avs_writedata)) == $past(avs_writedata))
    else $error("manual set write did not mark pending");
  AST_MAN_HOLD: assert property (1'b1 |=> ($past(man_keep) & ~pending.manual) == 32'h0)
    else $error("manual bit dropped without service");
  AST_REQ_ANY: assert property (request_any == (|pending))
    else $error("request flag disagrees with pending bits");
endmodule
bind deec_top deec_top_checker deec_top_checker_inst (.clk(clk), .reset(reset), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .tc_chain(tc_chain), .early_chain(early_chain), .serviced(serviced),
  .pending(pending), .request_any(request_any));

/* File: sim/tb.sv */
// testbench: register and event scenarios for the event block
`timescale 1ns/100ps
module tb;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, request_any, send, via_early;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, ext_event_pin, q;
  logic [5:0] code;
  deec_pkg::deec_chain_t tc_chain, early_chain;
  deec_pkg::deec_vec_t serviced, pending;
  int err_total, compares;
  deec_top deec_top_inst (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_event_pin(ext_event_pin), .tc_chain(tc_chain),
    .early_chain(early_chain), .serviced(serviced), .pending(pending), .request_any(request_any));
  deec_tc_model deec_tc_model_inst (.clk(clk), .send(send), .via_early(via_early), .code(code),
    .tc_chain(tc_chain), .early_chain(early_chain));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until the edge that samples waitrequest low; only the watchdog ends a wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk($sformatf("reg_%h", a), e, q);
  endtask
  task automatic chain(input logic e, input logic [5:0] c, input logic [31:0] svc);
    send <= 1;
    via_early <= e;
    code <= c;
    @(posedge clk);
    send <= 0;
    serviced.chained <= svc;
    @(posedge clk);
    serviced.chained <= 0;
    @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report;
  end
  initial begin
    {reset, avs_read, avs_write, send, via_early} = 5'h10;
    {avs_address, avs_writedata, ext_event_pin, code, serviced} = '0;
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rc(8'h04, 0);
    rc(8'h08, 0);
    $display("test reset done");
    bus(1, 8'h08, 32'hffffffff);
    rc(8'h08, 0);
    bus(1, 8'h10, 32'hf0);
    rc(8'h08, 32'hf0);
    bus(1, 8'h0c, 32'h30);
    rc(8'h08, 32'hc0);
    rc(8'h0c, 0);
    $display("test enable mask done");
    bus(1, 8'h00, 32'h5);
    chk("manual", 32'h5, pending.manual);
    bus(1, 8'h18, 32'h5);
    chk("manual", 32'h5, pending.manual);
    bus(1, 8'h00, 32'h1);
    rc(8'h1c, 32'h1);
    bus(1, 8'h1c, 32'hffffffff);
    serviced.manual <= 32'h5;
    @(posedge clk);
    serviced.manual <= 0;
    @(posedge clk);
    #1;
    chk("manual", 0, pending.manual);
    $display("test manual done");
    chain(0, 6'h03, 0);
    chk("chained", 32'h8, pending.chained);
    chk("request", 1, request_any);
    chain(1, 6'h03, 0);
    rc(8'h1c, 32'h8);
    chain(0, 6'h03, 32'h8);
    chk("chained", 32'h8, pending.chained);
    chain(1, 6'h23, 32'h8);
    chk("chained", 0, pending.chained);
    chain(0, 6'h03, 32'h8);
    chk("chained", 32'h8, pending.chained);
    $display("test chain done");
    ext_event_pin <= 32'h42;
    repeat (6) @(posedge clk);
    #1;
    chk("external", 32'h40, pending.external);
    rc(8'h14, 32'h42);
    bus(1, 8'h10, 32'h2);
    chk("external", 32'h42, pending.external);
    $display("test external done");
    final_report;
  end
endmodule

/* File: src/deec_pkg.sv */
// package: register map, reset values and carriers for the event block
package deec_pkg;

  // ==========================================
  // sizes
  localparam int unsigned NUM_EVENTS = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned CODE_W     = 6;

  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_MANUAL_SET   = 8'h00;
  localparam logic [7:0] OFS_CHAIN_PEND   = 8'h04;
  localparam logic [7:0] OFS_ENABLE_MASK  = 8'h08;
  localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_ENABLE_SET   = 8'h10;
  localparam logic [7:0] OFS_EXT_LATCH    = 8'h14;
  localparam logic [7:0] OFS_EXT_CLEAR    = 8'h18;
  localparam logic [7:0] OFS_MISSED       = 8'h1c;

  // ==========================================
  // reset and read values
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  localparam logic        RST_BIT       = 1'h0;

  // ==========================================
  // completion code field: bit 5 set names no event of this block
  localparam int unsigned CODE_HI_BIT = 5;

  // ==========================================
  // carriers
  typedef struct packed {
    logic                valid;
    logic                inter_chain_en;
    logic                final_chain_en;
    logic [CODE_W-1:0]   completion_code;
  } deec_chain_t;

  typedef struct packed {
    logic [NUM_EVENTS-1:0] manual;
    logic [NUM_EVENTS-1:0] chained;
    logic [NUM_EVENTS-1:0] external;
  } deec_vec_t;

endpackage

/* File: src/deec_top.sv */
// module: event latch, manual set, chained set and enable mask with avalon-mm registers
`timescale 1ns/100ps

// Overview of operation
// - write one to manual set marks pending
// - chaining entry sets bit chosen by code
// - chained bit is offered for transfer request
// - chained bits ignore the enable mask
// - set from controllers or early-completion path
// - chained bit cleared by hardware after service
// - repeat chained code flags missed event
// - set beats clear; repeat flags missed
// - set with clear on clear bit stays set
// - mask bit gates latched external event
// - external latch captures even disabled events
// - enabling a pending event processes it
// - mask ignores chained and manual events
// - mask readable, not directly writable
// - enable clear write one clears mask
// - enable set write one sets mask
// - manual bit held until request submitted
// - repeat manual write flags missed event
module deec_top (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [31:0]          ext_event_pin,
  input  wire deec_pkg::deec_chain_t tc_chain,
  input  wire deec_pkg::deec_chain_t early_chain,
  input  wire deec_pkg::deec_vec_t   serviced,
  output deec_pkg::deec_vec_t        pending,
  output logic                      request_any
);

  // ==========================================
  // helpers
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      lane_mask[8*i +: 8] = {8{be[i]}};
    end
  endfunction

  function automatic logic [31:0] code_onehot(input deec_pkg::deec_chain_t c);
    logic       chaining;
    logic       in_range;
    logic [4:0] index;
    chaining    = c.inter_chain_en | c.final_chain_en;
    in_range    = ~c.completion_code[deec_pkg::CODE_HI_BIT];
    index       = c.completion_code[4:0];
    code_onehot = (c.valid & chaining & in_range) ? (32'h0000_0001 << index) : 32'h0000_0000;
  endfunction

  // set terms are or-ed last so a set beats a clear in the same cycle
  function automatic logic [31:0] set_over_clear(input logic [31:0] q,
                                                 input logic [31:0] clr,
                                                 input logic [31:0] set);
    set_over_clear = (q & ~clr) | set;
  endfunction

  // ==========================================
  // state
  logic [31:0] manual_event_set_q;
  logic [31:0] manual_event_set_d;

  logic [31:0] chained_event_pending_q;
  logic [31:0] chained_event_pending_d;

  logic [31:0] event_enable_mask_q;
  logic [31:0] event_enable_mask_d;

  logic [31:0] external_event_latch_q;
  logic [31:0] external_event_latch_d;

  logic [31:0] missed_event_flags_q;
  logic [31:0] missed_event_flags_d;

  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic [31:0] sync3_q;

  logic        ack_q;
  logic        ack_d;

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ==========================================
  // bus decode
  wire         req        = avs_read | avs_write;
  wire         wr_go      = avs_write & ack_q;
  wire [31:0]  wmask      = lane_mask(avs_byteenable);
  wire [31:0]  wbits      = avs_writedata & wmask;
  wire         hit_mset   = avs_address == deec_pkg::OFS_MANUAL_SET;
  wire         hit_eclr   = avs_address == deec_pkg::OFS_ENABLE_CLEAR;
  wire         hit_eset   = avs_address == deec_pkg::OFS_ENABLE_SET;
  wire         hit_xclr   = avs_address == deec_pkg::OFS_EXT_CLEAR;
  wire         hit_missed = avs_address == deec_pkg::OFS_MISSED;

  // write strobes, one bit per event; a single write may hit any bits
  wire [31:0]  wr_mset    = (wr_go & hit_mset)   ? wbits : 32'h0000_0000;
  wire [31:0]  wr_eclr    = (wr_go & hit_eclr)   ? wbits : 32'h0000_0000;
  wire [31:0]  wr_eset    = (wr_go & hit_eset)   ? wbits : 32'h0000_0000;
  wire [31:0]  wr_xclr    = (wr_go & hit_xclr)   ? wbits : 32'h0000_0000;
  wire [31:0]  wr_mclr    = (wr_go & hit_missed) ? wbits : 32'h0000_0000;

  // ==========================================
  // event sources
  wire [31:0]  ext_rise   = sync2_q & ~sync3_q;
  wire [31:0]  chain_tc    = code_onehot(tc_chain);
  wire [31:0]  chain_early = code_onehot(early_chain);
  wire [31:0]  chain_set   = chain_tc | chain_early;

  // ==========================================
  // missed-event detection: a new set on a bit already set loses one
  wire [31:0]  miss_manual = wr_mset & manual_event_set_q;
  wire [31:0]  miss_chain  = chain_set & chained_event_pending_q;
  wire [31:0]  miss_ext    = ext_rise & external_event_latch_q;
  wire [31:0]  miss_all    = miss_manual | miss_chain | miss_ext;

  // ==========================================
  // per-register clear terms
  // manual bits ignore the external clear strobe
  wire [31:0]  clr_manual  = serviced.manual;
  // no software clear path for chained bits
  wire [31:0]  clr_chain   = serviced.chained;
  wire [31:0]  clr_mask    = wr_eclr;
  wire [31:0]  clr_latch   = serviced.external | wr_xclr;
  wire [31:0]  clr_missed  = wr_mclr;

  // ==========================================
  // next state
  assign manual_event_set_d =
    set_over_clear(manual_event_set_q, clr_manual, wr_mset);

  // chaining ignores the mask
  assign chained_event_pending_d =
    set_over_clear(chained_event_pending_q, clr_chain, chain_set);

  // the mask only moves through its strobes, never a direct write
  assign event_enable_mask_d =
    set_over_clear(event_enable_mask_q, clr_mask, wr_eset);

  // latch captures whatever the mask holds
  assign external_event_latch_d =
    set_over_clear(external_event_latch_q, clr_latch, ext_rise);

  assign missed_event_flags_d =
    set_over_clear(missed_event_flags_q, clr_missed, miss_all);

  // ==========================================
  // read mux
  always_comb begin
    case (avs_address)
      deec_pkg::OFS_MANUAL_SET: begin
        rdata_d = manual_event_set_q;
      end
      deec_pkg::OFS_CHAIN_PEND: begin
        rdata_d = chained_event_pending_q;
      end
      deec_pkg::OFS_ENABLE_MASK: begin
        rdata_d = event_enable_mask_q;
      end
      deec_pkg::OFS_EXT_LATCH: begin
        rdata_d = external_event_latch_q;
      end
      deec_pkg::OFS_MISSED: begin
        rdata_d = missed_event_flags_q;
      end
      deec_pkg::OFS_ENABLE_CLEAR,
      deec_pkg::OFS_ENABLE_SET,
      deec_pkg::OFS_EXT_CLEAR: begin
        rdata_d = deec_pkg::RST_ZERO;
      end
      default: begin
        rdata_d = deec_pkg::READ_UNMAPPED;
      end
    endcase
  end

  // ==========================================
  // bus handshake
  // one wait state per access, answer on the second edge
  assign ack_d = req & ~ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  // ==========================================
  // pending toward prioritization
  assign pending.manual   = manual_event_set_q;
  assign pending.chained  = chained_event_pending_q;
  assign pending.external = external_event_latch_q & event_enable_mask_q;

  wire         any_manual  = |manual_event_set_q;
  wire         any_chain   = |chained_event_pending_q;
  wire         any_ext     = |pending.external;
  assign request_any = any_manual | any_chain | any_ext;

  // ==========================================
  // pin synchroniser: two flops, then an edge flop
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= deec_pkg::RST_ZERO;
    end else begin
      sync1_q <= ext_event_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync2_q <= deec_pkg::RST_ZERO;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync3_q <= deec_pkg::RST_ZERO;
    end else begin
      sync3_q <= sync2_q;
    end
  end

  // ==========================================
  // event registers
  always_ff @(posedge clk) begin
    if (reset) begin
      manual_event_set_q <= deec_pkg::RST_ZERO;
    end else begin
      manual_event_set_q <= manual_event_set_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chained_event_pending_q <= deec_pkg::RST_ZERO;
    end else begin
      chained_event_pending_q <= chained_event_pending_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      event_enable_mask_q <= deec_pkg::RST_ZERO;
    end else begin
      event_enable_mask_q <= event_enable_mask_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      external_event_latch_q <= deec_pkg::RST_ZERO;
    end else begin
      external_event_latch_q <= external_event_latch_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      missed_event_flags_q <= deec_pkg::RST_ZERO;
    end else begin
      missed_event_flags_q <= missed_event_flags_d;
    end
  end

  // ==========================================
  // bus answer
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= deec_pkg::RST_BIT;
    end else begin
      ack_q <= ack_d;
    end
  end

  // read data captured in the wait cycle, shown in the answer cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= deec_pkg::RST_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule
